/* File: design/wsr_top.sv */
// Watchdog with stop-mode recovery, locked reload path and AXI4-Lite registers.
`timescale 1ns/1ps
`include "wsr_consts.svh"
module wsr_top import wsr_pkg::*; #(
	parameter int PINS = 8,
	parameter int ADDR_W = 6,
	parameter logic [23:0] RELOAD_RST = `WSR_RELOAD_RST
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [PINS-1:0] pins_in,
	input wire logic stop_req_in,
	input wire logic refresh_in,
	output logic stopped_out,
	output logic wd_reset_out,
	output logic irq_out
);
	localparam int RC = `WSR_RECOV_CYC;
	localparam int RCW = $clog2(RC + 1);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic aw_full;
	logic w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_go;
	logic rd_go;
	logic rd_status;
	wsr_lock_t lock_st;
	wsr_mode_t mode;
	logic [7:0] reload_upper_byte;
	logic [7:0] reload_high_byte;
	logic [7:0] reload_low_byte;
	logic [23:0] reload_val;
	logic [23:0] count;
	logic [`WSR_CTRL_W-1:0] ctrl;
	logic [PINS-1:0] wake_en;
	logic [PINS-1:0] port_input_data;
	logic [PINS-1:0] pin_level;
	logic pin_wake;
	logic en_d;
	logic tmo;
	logic [RCW-1:0] rec_cnt;
	logic recov_last;
	logic irq_pend;
	logic [3:0] stat_hi;
	logic [3:0] stat_set;
	logic [7:0] watchdog_status_unlock;
	logic [`WSR_IRQ_W-1:0] irq_stat;
	logic [`WSR_IRQ_W-1:0] irq_mask;
	logic [`WSR_IRQ_W-1:0] irq_set;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Word decode of an aligned register address.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] off);
		hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2));
	endfunction

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// ------------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------------
	// Address and data are taken in either order; the write acts once both are held.
	assign s_axi_awready_out = !aw_full;
	assign s_axi_wready_out = !w_full;
	assign wr_go = aw_full && w_full && !s_axi_bvalid_out;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
	assign rd_status = rd_go && hit(s_axi_araddr_in, `WSR_OFF_STATUS);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `WSR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && !aw_full) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid_in && !w_full) begin
				w_full <= 1'b1;
				w_byte <= s_axi_wdata_in[7:0];
				w_lane0 <= s_axi_wstrb_in[0];
			end else if (wr_go) begin
				w_full <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (aw_addr > ADDR_W'(`WSR_OFF_PORT_IN) + ADDR_W'(3)) ?
					`WSR_RESP_SLVERR : `WSR_RESP_OKAY;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Read multiplexer; narrow registers sit in the low byte.
	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (s_axi_araddr_in[ADDR_W-1:2])
			(ADDR_W-2)'(`WSR_OFF_STATUS >> 2): rd_byte = watchdog_status_unlock;
			(ADDR_W-2)'(`WSR_OFF_UPPER >> 2): rd_byte = reload_upper_byte;
			(ADDR_W-2)'(`WSR_OFF_HIGH >> 2): rd_byte = reload_high_byte;
			(ADDR_W-2)'(`WSR_OFF_LOW >> 2): rd_byte = reload_low_byte;
			(ADDR_W-2)'(`WSR_OFF_CTRL >> 2): rd_byte = 8'(ctrl);
			(ADDR_W-2)'(`WSR_OFF_WAKE_EN >> 2): rd_byte = 8'(wake_en);
			(ADDR_W-2)'(`WSR_OFF_IRQ_STAT >> 2): rd_byte = 8'(irq_stat);
			(ADDR_W-2)'(`WSR_OFF_IRQ_MASK >> 2): rd_byte = 8'(irq_mask);
			(ADDR_W-2)'(`WSR_OFF_PORT_IN >> 2): rd_byte = 8'(port_input_data);
			default: rd_hit = 1'b0;
		endcase
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `WSR_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= {24'h000000, rd_byte};
			s_axi_rresp_out <= rd_hit ? `WSR_RESP_OKAY : `WSR_RESP_SLVERR;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Unlock machine and reload bytes
	// ------------------------------------------------------------------------
	// Every write advances the machine or drops it back, except a repeated first unlock byte, which holds it; so a stray write closes the path.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lock_st <= WSR_LOCKED;
		end else if (wr_go) begin
			case (lock_st)
				WSR_LOCKED, WSR_GOT_FIRST: begin
					if (hit(aw_addr, `WSR_OFF_STATUS) && w_byte == `WSR_UNLOCK_FIRST) begin
						lock_st <= WSR_GOT_FIRST;
					end else if (lock_st == WSR_GOT_FIRST && hit(aw_addr, `WSR_OFF_STATUS) &&
						w_byte == `WSR_UNLOCK_SECOND) begin
						lock_st <= WSR_OPEN_UPPER;
					end else begin
						lock_st <= WSR_LOCKED;
					end
				end
				WSR_OPEN_UPPER: lock_st <= hit(aw_addr, `WSR_OFF_UPPER) ? WSR_OPEN_HIGH : WSR_LOCKED;
				WSR_OPEN_HIGH: lock_st <= hit(aw_addr, `WSR_OFF_HIGH) ? WSR_OPEN_LOW : WSR_LOCKED;
				WSR_OPEN_LOW: lock_st <= WSR_LOCKED;
				default: lock_st <= WSR_LOCKED;
			endcase
		end
	end

	// A reload byte only takes a write in its own open step.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			{reload_upper_byte, reload_high_byte, reload_low_byte} <= RELOAD_RST;
		end else if (wr_go && w_lane0) begin
			if (lock_st == WSR_OPEN_UPPER && hit(aw_addr, `WSR_OFF_UPPER))
				reload_upper_byte <= w_byte;
			if (lock_st == WSR_OPEN_HIGH && hit(aw_addr, `WSR_OFF_HIGH))
				reload_high_byte <= w_byte;
			if (lock_st == WSR_OPEN_LOW && hit(aw_addr, `WSR_OFF_LOW))
				reload_low_byte <= w_byte;
		end
	end

	assign reload_val = {reload_upper_byte, reload_high_byte, reload_low_byte};

	// ------------------------------------------------------------------------
	// Software control registers
	// ------------------------------------------------------------------------
	// Interrupt status is write-one-to-clear; a new event in the same cycle wins.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctrl <= '0;
			wake_en <= '0;
			irq_mask <= '0;
			irq_stat <= '0;
		end else begin
			if (wr_go && w_lane0 && hit(aw_addr, `WSR_OFF_CTRL))
				ctrl <= w_byte[`WSR_CTRL_W-1:0];
			if (wr_go && w_lane0 && hit(aw_addr, `WSR_OFF_WAKE_EN))
				wake_en <= w_byte[PINS-1:0];
			if (wr_go && w_lane0 && hit(aw_addr, `WSR_OFF_IRQ_MASK))
				irq_mask <= w_byte[`WSR_IRQ_W-1:0];
			if (wr_go && w_lane0 && hit(aw_addr, `WSR_OFF_IRQ_STAT))
				irq_stat <= (irq_stat & ~w_byte[`WSR_IRQ_W-1:0]) | irq_set;
			else
				irq_stat <= irq_stat | irq_set;
		end
	end

	assign irq_out = |(irq_stat & irq_mask);

	// ------------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------------
	// The counter is reloaded on the enabling edge, on refresh and after each time-out.
	assign tmo = ctrl[`WSR_CTRL_EN] && en_d && count == 24'h000000;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			en_d <= 1'b0;
			count <= RELOAD_RST;
		end else begin
			en_d <= ctrl[`WSR_CTRL_EN];
			if ((ctrl[`WSR_CTRL_EN] && !en_d) || refresh_in || tmo)
				count <= reload_val;
			else if (ctrl[`WSR_CTRL_EN])
				count <= count - 24'h000001;
		end
	end

	// ------------------------------------------------------------------------
	// Stop mode and recovery
	// ------------------------------------------------------------------------
	wsr_pin_wake #(.PINS(PINS), .FILT(`WSR_FILT_CYC)) u_pin_wake (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pins_in(pins_in),
		.wake_en_in(wake_en),
		.level_out(pin_level),
		.wake_out(pin_wake)
	);

	assign recov_last = (mode == WSR_RECOVER) && rec_cnt == RCW'(RC - 1);
	assign stopped_out = (mode != WSR_RUN);

	// A time-out or an enabled pin change ends stop; recovery then runs a fixed delay.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode <= WSR_RUN;
			rec_cnt <= '0;
		end else begin
			case (mode)
				WSR_RUN: if (stop_req_in) mode <= WSR_STOP;
				WSR_STOP: begin
					if (tmo || pin_wake) begin
						mode <= WSR_RECOVER;
						rec_cnt <= '0;
					end
				end
				WSR_RECOVER: begin
					rec_cnt <= rec_cnt + RCW'(1);
					if (recov_last) mode <= WSR_RUN;
				end
				default: mode <= WSR_RUN;
			endcase
		end
	end

	// Port data freeze in stop; the level seen at the end of recovery is what gets recorded.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			port_input_data <= '0;
		else if (mode == WSR_RUN || recov_last)
			port_input_data <= pin_level;
	end

	// A time-out outside run mode is held back until recovery ends.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			irq_pend <= 1'b0;
		else if (recov_last)
			irq_pend <= 1'b0;
		else if (tmo && mode != WSR_RUN)
			irq_pend <= 1'b1;
	end

	// Interrupt events.
	always_comb begin
		irq_set = '0;
		irq_set[`WSR_IRQ_TIMEOUT] = ctrl[`WSR_CTRL_IRQ_MODE] && ctrl[`WSR_CTRL_INT_EN] &&
			((tmo && mode == WSR_RUN) || (recov_last && (irq_pend || tmo)));
		irq_set[`WSR_IRQ_RECOV] = recov_last;
		irq_set[`WSR_IRQ_PIN] = (mode == WSR_RUN || recov_last) &&
			|((pin_level ^ port_input_data) & wake_en);
	end

	// ------------------------------------------------------------------------
	// Status register and reset request
	// ------------------------------------------------------------------------
	always_comb begin
		stat_set = 4'h0;
		stat_set[`WSR_HI_WD_RST] = tmo && mode == WSR_RUN && !ctrl[`WSR_CTRL_IRQ_MODE];
		stat_set[`WSR_HI_TIMEOUT] = tmo;
		stat_set[`WSR_HI_STOP] = mode == WSR_STOP && (tmo || pin_wake);
	end

	// Software never writes these bits; a read clears them, but a same-cycle event still lands.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			stat_hi <= `WSR_HI_RST;
		else
			stat_hi <= (rd_status ? 4'h0 : stat_hi) | stat_set;
	end

	assign watchdog_status_unlock = {stat_hi, 3'h0, lock_st != WSR_LOCKED};

	// In reset mode a time-out in run mode asks the system for a reset.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			wd_reset_out <= 1'b0;
		else
			wd_reset_out <= stat_set[`WSR_HI_WD_RST];
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	property p_stop_wd_wake;
		(mode == WSR_STOP && tmo) |=> (mode == WSR_RECOVER && stat_hi[`WSR_HI_TIMEOUT] && stat_hi[`WSR_HI_STOP]);
	endproperty
	a_stop_wd_wake: assert property (p_stop_wd_wake) else $error("Time-out in stop did not wake.");

	property p_irq_after_recov;
		$rose(irq_stat[`WSR_IRQ_TIMEOUT]) |-> mode == WSR_RUN;
	endproperty
	a_irq_after_recov: assert property (p_irq_after_recov) else $error("Watchdog irq during stop.");

	property p_pin_wake;
		(mode == WSR_STOP && pin_wake) |=> (mode == WSR_RECOVER && stat_hi[`WSR_HI_STOP]) ##(RC) mode == WSR_RUN;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("Pin change did not run recovery.");

	property p_port_frozen;
		mode == WSR_STOP |=> $stable(port_input_data);
	endproperty
	a_port_frozen: assert property (p_port_frozen) else $error("Port data moved in stop.");

	property p_unlock_no_effect;
		(wr_go && hit(aw_addr, `WSR_OFF_STATUS) && !rd_status && stat_set == 4'h0) |=> $stable(stat_hi);
	endproperty
	a_unlock_no_effect: assert property (p_unlock_no_effect) else $error("Status changed by write.");

	property p_locked_ignore;
		(wr_go && hit(aw_addr, `WSR_OFF_UPPER) && lock_st != WSR_OPEN_UPPER) |=> $stable(reload_upper_byte);
	endproperty
	a_locked_ignore: assert property (p_locked_ignore) else $error("Locked reload byte changed.");

	property p_stray_relock;
		(wr_go && lock_st == WSR_OPEN_UPPER && !hit(aw_addr, `WSR_OFF_UPPER)) |=> lock_st == WSR_LOCKED;
	endproperty
	a_stray_relock: assert property (p_stray_relock) else $error("Stray write left lock open.");

	property p_refresh_load;
		refresh_in |=> count == $past(reload_val);
	endproperty
	a_refresh_load: assert property (p_refresh_load) else $error("Refresh did not load counter.");

	property p_status_read;
		rd_status |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == $past(watchdog_status_unlock);
	endproperty
	a_status_read: assert property (p_status_read) else $error("Status read data wrong.");

	property p_read_clear;
		(rd_status && stat_set == 4'h0) |=> stat_hi == 4'h0;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("Status read did not clear.");

	property p_count_down;
		(ctrl[`WSR_CTRL_EN] && en_d && !refresh_in && !tmo) ##1 ctrl[`WSR_CTRL_EN] |-> count == $past(count) - 24'h000001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("Counter did not decrement.");

	c_wd_wake: cover property (mode == WSR_STOP && tmo);
	c_pin_wake: cover property (mode == WSR_STOP && pin_wake && !tmo);
	c_reload_done: cover property (wr_go && lock_st == WSR_OPEN_LOW && hit(aw_addr, `WSR_OFF_LOW));
	c_irq: cover property ($rose(irq_out));
endmodule

/* File: design/wsr_consts.svh */
// Constants of the watchdog with stop-mode recovery and locked reload path.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef WSR_CONSTS_SVH
`define WSR_CONSTS_SVH

// Register byte offsets.
`define WSR_OFF_STATUS 6'h00
`define WSR_OFF_UPPER 6'h04
`define WSR_OFF_HIGH 6'h08
`define WSR_OFF_LOW 6'h0C
`define WSR_OFF_CTRL 6'h10
`define WSR_OFF_WAKE_EN 6'h14
`define WSR_OFF_IRQ_STAT 6'h18
`define WSR_OFF_IRQ_MASK 6'h1C
`define WSR_OFF_PORT_IN 6'h20

// Unlock bytes.
`define WSR_UNLOCK_FIRST 8'h55
`define WSR_UNLOCK_SECOND 8'hAA

// Upper status nibble bit positions, lower nibble bit 0 shows the unlock.
`define WSR_HI_SYS_RST 3
`define WSR_HI_WD_RST 2
`define WSR_HI_TIMEOUT 1
`define WSR_HI_STOP 0
`define WSR_HI_RST 4'h8

// Control register bits.
`define WSR_CTRL_EN 0
`define WSR_CTRL_IRQ_MODE 1
`define WSR_CTRL_INT_EN 2
`define WSR_CTRL_W 3

// Interrupt status and mask bits.
`define WSR_IRQ_TIMEOUT 0
`define WSR_IRQ_RECOV 1
`define WSR_IRQ_PIN 2
`define WSR_IRQ_W 3

// AXI responses.
`define WSR_RESP_OKAY 2'h0
`define WSR_RESP_SLVERR 2'h2

// Timing: clock period, recovery delay and pin glitch filter.
`define WSR_CLK_NS 4
`define WSR_RECOV_NS 40
`define WSR_RECOV_CYC ((`WSR_RECOV_NS + `WSR_CLK_NS - 1) / `WSR_CLK_NS)
`define WSR_FILT_NS 10
`define WSR_FILT_CYC ((`WSR_FILT_NS + `WSR_CLK_NS - 1) / `WSR_CLK_NS)

// Reset value of the reload value.
`define WSR_RELOAD_RST 24'h000100

`endif

/* File: design/wsr_pkg.sv */
// Types shared by the watchdog files.
package wsr_pkg;
	typedef enum logic [2:0] {
		WSR_LOCKED = 3'h0,
		WSR_GOT_FIRST = 3'h1,
		WSR_OPEN_UPPER = 3'h2,
		WSR_OPEN_HIGH = 3'h3,
		WSR_OPEN_LOW = 3'h4
	} wsr_lock_t;
	typedef enum logic [1:0] {
		WSR_RUN = 2'h0,
		WSR_STOP = 2'h1,
		WSR_RECOVER = 2'h2
	} wsr_mode_t;
endpackage

/* File: design/wsr_pin_wake.sv */
// Pin synchroniser, glitch filter and wake change detector.
`timescale 1ns/1ps
`include "wsr_consts.svh"
module wsr_pin_wake #(
	parameter int PINS = 8,
	parameter int FILT = `WSR_FILT_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [PINS-1:0] pins_in,
	input wire logic [PINS-1:0] wake_en_in,
	output logic [PINS-1:0] level_out,
	output logic wake_out
);
	localparam int CW = $clog2(FILT + 1);
	logic [PINS-1:0] sync1;
	logic [PINS-1:0] sync2;
	logic [PINS-1:0] level_d;

	// Two flops per pin; only the second one is read by the filter.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sync1 <= '0;
			sync2 <= '0;
			level_d <= '0;
		end else begin
			sync1 <= pins_in;
			sync2 <= sync1;
			level_d <= level_out;
		end
	end

	// A new level is taken only after it held for the filter time, so short glitches never wake.
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			logic [CW-1:0] cnt;
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					cnt <= '0;
					level_out[g] <= 1'b0;
				end else if (sync2[g] == level_out[g]) begin
					cnt <= '0;
				end else if (cnt == CW'(FILT - 1)) begin
					cnt <= '0;
					level_out[g] <= sync2[g];
				end else begin
					cnt <= cnt + CW'(1);
				end
			end
		end
	endgenerate

	// Either direction of change on an enabled pin is a wake.
	assign wake_out = |((level_out ^ level_d) & wake_en_in);
endmodule

/* File: testbench/wsr_top_tb.sv */
// Self-checking bench for the watchdog with stop-mode recovery and locked reload path.
`timescale 1ns/1ps
`include "wsr_consts.svh"
module wsr_top_tb import wsr_pkg::*;;
	// ------------------------------------------------------------
	// Clock, reset and the design
	// ------------------------------------------------------------
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] pins = 8'h00;
	logic stop_req = 1'b0, refresh = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, stopped, wd_reset, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd_data;
	int errors = 0, total_checks = 0;
	int n, k, r, p, idx, rl;

	// A short reload keeps every time-out within a few dozen cycles.
	wsr_top #(.PINS(8), .ADDR_W(6), .RELOAD_RST(24'h000010)) i_dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.pins_in(pins), .stop_req_in(stop_req), .refresh_in(refresh),
		.stopped_out(stopped), .wd_reset_out(wd_reset), .irq_out(irq)
	);

	// Free-running 250 MHz clock.
	always #2 clk_in = ~clk_in;

	// ------------------------------------------------------------
	// Bus tasks and comparisons
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Each task waits one edge first so that no valid or ready is assigned twice in one step.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
		if (n == 100) chk("write_answer", 32'h0, 32'h1);
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n == 100) chk("read_answer", 32'h0, 32'h1);
	endtask

	task automatic rdchk(input string what, input logic [5:0] a, input logic [31:0] exp);
		rd(a);
		chk(what, exp, rd_data);
	endtask

	task automatic stop();
		@(posedge clk_in);
		stop_req <= 1'b1;
		@(posedge clk_in);
		stop_req <= 1'b0;
		@(posedge clk_in);
	endtask

	// Waits for the end of recovery; an irq seen before the final stopped cycle is flagged in r.
	task automatic wait_run();
		r = 0;
		p = 0;
		for (n = 0; n < 3000 && stopped; n++) begin
			if (p) r = 1;
			p = irq;
			@(posedge clk_in);
		end
		if (n == 3000) chk("recovery_end", 32'h0, 32'h1);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Main sequence; the low reload byte and the wake pin are drawn at random.
	initial begin
		r = $urandom(8);
		rl = 12 + $urandom % 28;
		idx = $urandom % 8;
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rdchk("ctrl", `WSR_OFF_CTRL, 32'h0);
		wr(`WSR_OFF_LOW, 8'($urandom));
		rdchk("low_locked", `WSR_OFF_LOW, 32'h10);
		wr(`WSR_OFF_UPPER, 8'($urandom));
		rdchk("upper_locked", `WSR_OFF_UPPER, 32'h0);
		done("locked");
		wr(`WSR_OFF_STATUS, `WSR_UNLOCK_FIRST);
		wr(`WSR_OFF_STATUS, `WSR_UNLOCK_SECOND);
		rdchk("status_unlock", `WSR_OFF_STATUS, 32'h81);
		rdchk("status_cleared", `WSR_OFF_STATUS, 32'h01);
		wr(`WSR_OFF_UPPER, 8'h00);
		wr(`WSR_OFF_HIGH, 8'h00);
		wr(`WSR_OFF_LOW, 8'(rl));
		rdchk("low_loaded", `WSR_OFF_LOW, 32'(rl));
		rdchk("status_relocked", `WSR_OFF_STATUS, 32'h0);
		done("unlock");
		// Broken sequences, and an upper write without its byte lane, leave the reload untouched.
		for (k = 0; k < 3; k++) begin
			wr(`WSR_OFF_STATUS, `WSR_UNLOCK_FIRST);
			if (k == 0) wr(`WSR_OFF_WAKE_EN, 8'h00);
			wr(`WSR_OFF_STATUS, `WSR_UNLOCK_SECOND);
			if (k == 1) wr(`WSR_OFF_CTRL, 8'h00);
			wstrb <= (k == 2) ? 4'h0 : 4'hF;
			wr(`WSR_OFF_UPPER, 8'h03);
			wstrb <= 4'hF;
			wr(`WSR_OFF_LOW, 8'h03);
			rdchk("low_kept", `WSR_OFF_LOW, 32'(rl));
			rdchk("upper_kept", `WSR_OFF_UPPER, 32'h0);
		end
		done("interrupted");
		// Regular refreshes hold off the time-out; one final refresh starts a measured count.
		wr(`WSR_OFF_CTRL, 8'h01);
		r = 0;
		for (k = 0; k < 8 * (rl / 2); k++) begin
			@(posedge clk_in);
			refresh <= (k % (rl / 2) == 0);
			if (wd_reset) r++;
		end
		chk("reset_while_refreshed", 32'h0, 32'(r));
		@(posedge clk_in);
		refresh <= 1'b1;
		@(posedge clk_in);
		refresh <= 1'b0;
		for (n = 1; n < 200 && !wd_reset; n++) @(posedge clk_in);
		chk("timeout_span", 32'h1, 32'(n >= rl + 1 && n <= rl + 5));
		wr(`WSR_OFF_CTRL, 8'h00);
		rdchk("status_wd_reset", `WSR_OFF_STATUS, 32'h60);
		done("timeout");
		// Time-out in stop mode with interrupt mode on; the irq must wait for recovery.
		wr(`WSR_OFF_IRQ_STAT, 8'h07);
		wr(`WSR_OFF_IRQ_MASK, 8'h03);
		wr(`WSR_OFF_CTRL, 8'h07);
		stop();
		chk("stopped", 32'h1, 32'(stopped));
		wait_run();
		chk("irq_in_stop", 32'h0, 32'(r));
		chk("irq_after", 32'h1, 32'(irq));
		wr(`WSR_OFF_CTRL, 8'h00);
		rdchk("status_stop_to", `WSR_OFF_STATUS, 32'h30);
		wr(`WSR_OFF_IRQ_MASK, 8'h00);
		chk("irq_masked", 32'h0, 32'(irq));
		wr(`WSR_OFF_IRQ_MASK, 8'h03);
		chk("irq_unmasked", 32'h1, 32'(irq));
		wr(`WSR_OFF_IRQ_STAT, 8'h07);
		chk("irq_cleared", 32'h0, 32'(irq));
		rdchk("irq_status", `WSR_OFF_IRQ_STAT, 32'h0);
		done("stop_timeout");
		// Time-out in run mode with interrupt mode on: never a reset pulse, an irq only with interrupts enabled.
		for (k = 0; k < 2; k++) begin
			wr(`WSR_OFF_CTRL, (k == 1) ? 8'h07 : 8'h03);
			r = 0;
			repeat (rl + 4) begin
				@(posedge clk_in);
				if (wd_reset) r++;
			end
			wr(`WSR_OFF_CTRL, 8'h00);
			chk("run_irq", 32'(k), 32'(irq));
			chk("run_no_reset", 32'h0, 32'(r));
			rdchk("status_run_to", `WSR_OFF_STATUS, 32'h20);
			wr(`WSR_OFF_IRQ_STAT, 8'h07);
		end
		done("run_timeout");
		// Pin wake: a six-cycle pulse that passes the filter and ends during recovery, a lasting rise and a lasting fall.
		wr(`WSR_OFF_WAKE_EN, 8'(1 << idx));
		wr(`WSR_OFF_IRQ_MASK, 8'h04);
		for (k = 0; k < 3; k++) begin
			stop();
			pins[idx] <= (k != 2);
			if (k == 0) begin
				repeat (6) @(posedge clk_in);
				pins[idx] <= 1'b0;
			end
			wait_run();
			chk("pin_woke", 32'h0, 32'(stopped));
			rdchk("status_pin", `WSR_OFF_STATUS, 32'h10);
			rdchk("port_data", `WSR_OFF_PORT_IN, 32'(k == 1) << idx);
			rd(`WSR_OFF_IRQ_STAT);
			chk("pin_irq", (k == 0) ? 32'h0 : 32'h4, rd_data & 32'h4);
			wr(`WSR_OFF_IRQ_STAT, 8'h07);
		end
		done("pin_wake");
		// Unmapped addresses answer with an error and read as zero.
		wr(6'h24, 8'hFF);
		chk("unmapped_wresp", 32'(`WSR_RESP_SLVERR), 32'(resp));
		rd(6'h3C);
		chk("unmapped_rresp", 32'(`WSR_RESP_SLVERR), 32'(resp));
		chk("unmapped_rdata", 32'h0, rd_data);
		done("unmapped");
		end_of_test();
	end

	// Watchdog on the bench itself: the run needs far less than this span.
	initial begin
		#200000;
		errors++;
		end_of_test();
	end
endmodule
